// ==== bench/alu_flag_const_shift_ops_chk.sv ====
// Concurrent checks on the datapath slice ports.
`include "alu_consts.svh"
`default_nettype none
module alu_flag_const_shift_ops_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Instruction and operands
    input wire logic [4:0] alu_op,
    input wire logic [3:0] shift_op,
    input wire logic [15:0] shift_in,
    input wire logic [3:0] shift_value_port,
    // Results
    input wire logic [15:0] alu_result,
    input wire logic carry_out,
    input wire logic condition_flag_out,
    input wire logic [15:0] shift_result,
    input wire logic [3:0] shift_amount_one,
    input wire logic [3:0] shift_amount_two
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    AST_SEL_ZERO: assert property (alu_op inside {[5'h18:5'h1b]} |=> alu_result == 16'h0000)
        else $error("flag select result not zero");
    AST_OVF_SEL: assert property (alu_op == `OP_FLAG_OVF |=> !condition_flag_out)
        else $error("flag set on overflow select");
    AST_ZERO_SEL: assert property (alu_op == `OP_FLAG_ZERO |=> condition_flag_out)
        else $error("flag not set on zero select");
    AST_ZERO_HOLD: assert property (alu_op == `OP_FLAG_ZERO ##1 alu_op == 5'h08 |=>
        condition_flag_out == (alu_result == 16'h0000)) else $error("zero mode lost");
    AST_ONE: assert property (alu_op == `OP_CONST_ONE |=> alu_result == `VAL_ONE)
        else $error("bad constant one");
    AST_BYTE: assert property (alu_op == `OP_CONST_BYTE |=> alu_result == `VAL_BYTE)
        else $error("bad byte constant");
    AST_NIB_ALT: assert property (alu_op inside {`OP_CONST_NIB, `OP_CONST_ALT} |=>
        alu_result == ($past(alu_op[0]) ? `VAL_ALT : `VAL_NIB)) else $error("bad constant");
    AST_CLEAR: assert property (alu_op == `OP_CLEAR_ALL |=> alu_result == 16'h0000 &&
        !carry_out && shift_amount_one == 4'h0 && shift_amount_two == 4'h0)
        else $error("clear left state");
    AST_LOAD_TWO: assert property (shift_op == `SH_LOAD_TWO && alu_op != 5'h00 |=>
        shift_amount_two == $past(shift_value_port) && shift_result == $past(shift_in))
        else $error("second amount load wrong");
    AST_ROTL: assert property (shift_op == `SH_ROTL_PORT && alu_op != 5'h00 |=>
        shift_result == (($past(shift_in) << $past(shift_value_port)) |
        ($past(shift_in) >> (16 - $past(shift_value_port))))) else $error("rotate left wrong");
    cover property (alu_op == `OP_FLAG_ZERO ##1 alu_op == 5'h08);
    cover property (shift_op == `SH_LOAD_ONE ##1 shift_op == `SH_LSL_ONE);
    cover property (alu_op == `OP_CLEAR_ALL);
endmodule // alu_flag_const_shift_ops_chk
bind alu_flag_const_shift_ops alu_flag_const_shift_ops_chk chk (.core_clk, .sys_rst, .alu_op,
    .shift_op, .shift_in, .shift_value_port, .alu_result, .carry_out, .condition_flag_out,
    .shift_result, .shift_amount_one, .shift_amount_two);
`default_nettype wire

// ==== bench/op_source.sv ====
// Controller model presenting fresh operands every cycle.
`default_nettype none
module op_source (
    // Clock
    input wire logic core_clk,
    // Control
    input wire logic make_zero,
    // Operands
    output logic [15:0] alu_a,
    output logic [15:0] alu_b,
    output logic carry_in,
    output logic [15:0] shift_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] r;
    initial begin
        {alu_a, alu_b, carry_in, shift_in} = '0;
    end
    // Operands change just after an edge and hold for the whole cycle.
    always @(posedge core_clk) begin
        r = $urandom;
        alu_a <= r[15:0];
        alu_b <= make_zero ? 16'h0000 - r[15:0] : r[31:16];
        carry_in <= make_zero ? 1'b0 : r[7];
        shift_in <= 16'($urandom);
    end
endmodule // op_source
`default_nettype wire

// ==== bench/test_alu_flag_const_shift_ops.sv ====
// Self-checking bench for the flag, constant and shift datapath slice.
`include "alu_consts.svh"
`default_nettype none
module test_alu_flag_const_shift_ops;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] res;
        logic co, fl, fc;
        logic [15:0] sr;
        logic [3:0] a1, a2;
    } exp_type;
    logic core_clk, sys_rst, carry_out, condition_flag_out, make_zero;
    logic [4:0] alu_op;
    logic [3:0] shift_op, shift_value_port, shift_amount_one, shift_amount_two, a1, a2, n;
    logic [15:0] alu_result, shift_result, sh, c15;
    wire logic [15:0] alu_a, alu_b, shift_in;
    wire logic carry_in;
    logic [16:0] s;
    logic [1:0] mode;
    logic [4:0] pick [12] = '{5'h00, 5'h08, 5'h08, 5'h08, 5'h18, 5'h19, 5'h1a, 5'h1b,
        5'h1c, 5'h1d, 5'h1e, 5'h1f};
    exp_type q[$];
    exp_type g;
    int mismatches, samples_checked;
    logic armed, ov;
    op_source src (.core_clk(core_clk), .make_zero(make_zero), .alu_a(alu_a), .alu_b(alu_b),
        .carry_in(carry_in), .shift_in(shift_in));
    alu_flag_const_shift_ops dut (.core_clk(core_clk), .sys_rst(sys_rst), .alu_op(alu_op),
        .shift_op(shift_op), .alu_a(alu_a), .alu_b(alu_b), .carry_in(carry_in),
        .shift_in(shift_in), .shift_value_port(shift_value_port), .alu_result(alu_result),
        .carry_out(carry_out), .condition_flag_out(condition_flag_out),
        .shift_result(shift_result), .shift_amount_one(shift_amount_one),
        .shift_amount_two(shift_amount_two));
    always #2.5 core_clk = ~core_clk;
    // The expectation is taken from the inputs sampled at this edge, before new ones land.
    task automatic step(input logic [4:0] op, input logic [3:0] sop, sv, input logic mz);
        exp_type e;
        @(posedge core_clk);
        e = '0;
        s = alu_a + alu_b + 17'(carry_in);
        c15 = {1'b0, alu_a[14:0]} + {1'b0, alu_b[14:0]} + 16'(carry_in);
        ov = s[16] ^ c15[15];
        n = shift_op < 4'h4 ? shift_value_port : (shift_op < 4'h6 ? a1 : a2);
        case (shift_op)
            4'h0, 4'h4, 4'h6: sh = shift_in >> n;
            4'h1, 4'h5, 4'h7: sh = shift_in << n;
            4'h2: sh = (shift_in >> n) | (shift_in << (5'd16 - n));
            4'h3: sh = (shift_in << n) | (shift_in >> (5'd16 - n));
            default: sh = shift_in;
        endcase
        if (shift_op == 4'h8) a1 = shift_value_port;
        if (shift_op == 4'h9) a2 = shift_value_port;
        e.fc = alu_op == 5'h00 || alu_op[4:2] == 3'b110 || alu_op == 5'h08;
        case (alu_op)
            5'h00: {mode, a1, a2, sh} = '0;
            5'h08: begin
                {e.co, e.res} = s;
                e.fl = mode == 2'd3 ? s[15:0] == 16'h0000 : ov | (mode != 2'd0 && s[15] != s[14])
                    | (mode == 2'd2 && s[15] != s[13]);
            end
            `OP_CONST_ONE: e.res = `VAL_ONE;
            `OP_CONST_BYTE: e.res = `VAL_BYTE;
            `OP_CONST_NIB: e.res = `VAL_NIB;
            `OP_CONST_ALT: e.res = `VAL_ALT;
            default: begin
                mode = alu_op[1:0];
                e.fl = alu_op == `OP_FLAG_ZERO;
            end
        endcase
        {e.sr, e.a1, e.a2} = {sh, a1, a2};
        if (armed) q.push_back(e);
        alu_op <= op;
        shift_op <= op == 5'h00 ? 4'h4 : sop;
        shift_value_port <= sv;
        make_zero <= mz;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(negedge core_clk) begin
        if (q.size() > 0) begin
            g = q.pop_front();
            cmp(alu_result, g.res);
            cmp(16'(carry_out), 16'(g.co));
            if (g.fc) cmp(16'(condition_flag_out), 16'(g.fl));
            cmp(shift_result, g.sr);
            cmp({8'h00, shift_amount_one, shift_amount_two}, {8'h00, g.a1, g.a2});
        end
    end
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        alu_op = 5'h00;
        shift_op = 4'h0;
        shift_value_port = 4'h0;
        make_zero = 1'b0;
        {a1, a2, mode, armed, mismatches, samples_checked} = '0;
        void'($urandom(32'he4f4));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        armed = 1'b1;
        step(`OP_FLAG_ZERO, 4'h8, 4'hf, 1'b1);
        step(5'h08, 4'h5, 4'h0, 1'b0);
        step(5'h08, 4'h9, 4'h0, 1'b0);
        step(5'h00, 4'h7, 4'h0, 1'b0);
        repeat (3000) step(pick[$urandom % 12], 4'($urandom % 10), 4'($urandom),
            ($urandom % 4) == 0);
        repeat (2) step(5'h00, 4'h4, 4'h0, 1'b0);
        @(negedge core_clk);
        stop_test();
    end
endmodule // test_alu_flag_const_shift_ops
`default_nettype wire

// ==== core/alu_consts.svh ====
// Opcode encodings, constant patterns and widths for the flag/constant/shift datapath slice.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH
`define DATA_W 16
`define AMT_W 4
`define ALU_OP_W 5
`define SH_OP_W 4
`define OP_CLEAR_ALL 5'h00
`define OP_FLAG_OVF 5'h18
`define OP_FLAG_X2 5'h19
`define OP_FLAG_X4 5'h1a
`define OP_FLAG_ZERO 5'h1b
`define OP_CONST_ONE 5'h1c
`define OP_CONST_BYTE 5'h1d
`define OP_CONST_NIB 5'h1e
`define OP_CONST_ALT 5'h1f
`define SH_LSR_PORT 4'h0
`define SH_LSL_PORT 4'h1
`define SH_ROTR_PORT 4'h2
`define SH_ROTL_PORT 4'h3
`define SH_LSR_ONE 4'h4
`define SH_LSL_ONE 4'h5
`define SH_LSR_TWO 4'h6
`define SH_LSL_TWO 4'h7
`define SH_LOAD_ONE 4'h8
`define SH_LOAD_TWO 4'h9
`define VAL_ONE 16'h0001
`define VAL_BYTE 16'h00ff
`define VAL_NIB 16'h000f
`define VAL_ALT 16'h5555
`endif

// ==== core/alu_flag_const_shift_ops.sv ====
// Datapath slice: flag mode selection, constant outputs and logical barrel shifts.
// How it works
// - Opcode 18h selects overflow as the condition flag source.
// - Overflow flag is carry into MSB xor carry out of MSB.
// - Any flag-select opcode forces the ALU result to zero that cycle.
// - Opcode 19h flags results within a factor of two of overflow.
// - Opcode 1Ah flags results within a factor of four of overflow.
// - Opcode 1Bh flags results equal to zero.
// - Flag becomes active during the zero-select cycle itself.
// - Opcode 1Ch outputs constant 0001h.
// - Opcode 1Dh outputs constant 00ffh.
// - Opcode 1Eh outputs constant 000fh.
// - Opcode 1Fh outputs constant 5555h.
// - Shifter op 0 shifts right logically by the port amount.
// - Shifter op 1 shifts left logically by the port amount.
// - Shifter op 2 rotates right by the port amount.
// - Shifter op 3 rotates left by the port amount.
// - Shifter op 4 shifts right by the first amount register.
// - Shifter op 5 shifts left by the first amount register.
// - Shifter op 6 shifts right by the second amount register.
// - Shifter op 7 shifts left by the second amount register.
// - Shift amounts are unsigned 4-bit, zero to fifteen.
// - Clear-all zeroes registers and carry, returns flag to overflow mode.
// - Load ops 8 and 9 capture the port into amount registers.
`include "alu_consts.svh"
`default_nettype none
module alu_flag_const_shift_ops (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Instruction fields
    input wire logic [4:0] alu_op,
    input wire logic [3:0] shift_op,
    // Operands
    input wire logic [15:0] alu_a,
    input wire logic [15:0] alu_b,
    input wire logic carry_in,
    input wire logic [15:0] shift_in,
    input wire logic [3:0] shift_value_port,
    // Results
    output logic [15:0] alu_result,
    output logic carry_out,
    output logic condition_flag_out,
    output logic [15:0] shift_result,
    output logic [3:0] shift_amount_one,
    output logic [3:0] shift_amount_two
);
    // Opcodes 01h-17h are outside this slice; they pass A+B+carry_in so the flag
    // logic has an arithmetic result to watch.
    typedef struct packed {
        logic [15:0] alu_result;
        logic carry_out;
        logic condition_flag_out;
        logic [15:0] shift_result;
        logic [3:0] shift_amount_reg_one;
        logic [3:0] shift_amount_reg_two;
        alu_pkg::flag_mode_type mode;
    } state_type;

    state_type state_reg;
    state_type state_next;
    shift_if sif ();

    barrel_shifter shifter_inst (
        .sif(sif.shifter)
    );

    function automatic logic flag_of(input alu_pkg::flag_mode_type m, input logic [15:0] r,
                                     input logic ovf);
        logic res;
        res = 1'b0;
        unique case (m)
            alu_pkg::FLAG_OVF: res = ovf;
            alu_pkg::FLAG_X2: res = ovf | (r[15] ^ r[14]);
            alu_pkg::FLAG_X4: res = ovf | (r[15] ^ r[14]) | (r[15] ^ r[13]);
            alu_pkg::FLAG_ZERO: res = (r == 16'h0000);
        endcase
        return res;
    endfunction

    logic [15:0] low_sum;
    logic [16:0] full_sum;
    logic carry_msb;
    logic ovf;
    logic [15:0] result;
    alu_pkg::flag_mode_type mode_now;

    always_comb begin
        low_sum = {1'b0, alu_a[14:0]} + {1'b0, alu_b[14:0]} + {15'h0000, carry_in};
        carry_msb = low_sum[15];
        full_sum = {1'b0, alu_a} + {1'b0, alu_b} + {16'h0000, carry_in};
        ovf = carry_msb ^ full_sum[16];
        result = full_sum[15:0];
        mode_now = state_reg.mode;
        unique case (alu_op)
            `OP_FLAG_OVF: mode_now = alu_pkg::FLAG_OVF;
            `OP_FLAG_X2: mode_now = alu_pkg::FLAG_X2;
            `OP_FLAG_X4: mode_now = alu_pkg::FLAG_X4;
            `OP_FLAG_ZERO: mode_now = alu_pkg::FLAG_ZERO;
            `OP_CLEAR_ALL: mode_now = alu_pkg::FLAG_OVF;
            default: mode_now = state_reg.mode;
        endcase
        unique case (alu_op)
            `OP_FLAG_OVF, `OP_FLAG_X2, `OP_FLAG_X4, `OP_FLAG_ZERO: begin
                result = 16'h0000;
                ovf = 1'b0;
                full_sum = 17'h00000;
            end
            `OP_CONST_ONE: result = `VAL_ONE;
            `OP_CONST_BYTE: result = `VAL_BYTE;
            `OP_CONST_NIB: result = `VAL_NIB;
            `OP_CONST_ALT: result = `VAL_ALT;
            default: ;
        endcase
        if (alu_op >= `OP_FLAG_OVF) begin
            ovf = 1'b0;
            full_sum[16] = 1'b0;
        end

        sif.data_in = shift_in;
        sif.amount = shift_value_port;
        sif.kind = 2'h0;
        unique case (shift_op)
            `SH_LSR_PORT: sif.kind = 2'h0;
            `SH_LSL_PORT: sif.kind = 2'h1;
            `SH_ROTR_PORT: sif.kind = 2'h2;
            `SH_ROTL_PORT: sif.kind = 2'h3;
            `SH_LSR_ONE: sif.amount = state_reg.shift_amount_reg_one;
            `SH_LSL_ONE: begin
                sif.kind = 2'h1;
                sif.amount = state_reg.shift_amount_reg_one;
            end
            `SH_LSR_TWO: sif.amount = state_reg.shift_amount_reg_two;
            `SH_LSL_TWO: begin
                sif.kind = 2'h1;
                sif.amount = state_reg.shift_amount_reg_two;
            end
            // Loads and codes outside this slice pass the input unshifted.
            default: sif.amount = 4'h0;
        endcase

        state_next = state_reg;
        state_next.mode = mode_now;
        state_next.alu_result = result;
        state_next.carry_out = full_sum[16];
        // Flag is evaluated with the mode in force this cycle, so the zero
        // select sees its own forced zero and raises the flag at once.
        state_next.condition_flag_out = flag_of(mode_now, result, ovf);
        state_next.shift_result = sif.data_out;
        if (shift_op == `SH_LOAD_ONE) begin
            state_next.shift_amount_reg_one = shift_value_port;
        end
        if (shift_op == `SH_LOAD_TWO) begin
            state_next.shift_amount_reg_two = shift_value_port;
        end
        if (alu_op == `OP_CLEAR_ALL) begin
            state_next.alu_result = 16'h0000;
            state_next.carry_out = 1'b0;
            state_next.shift_result = 16'h0000;
            state_next.shift_amount_reg_one = 4'h0;
            state_next.shift_amount_reg_two = 4'h0;
            state_next.condition_flag_out = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= '{alu_result: 16'h0000, carry_out: 1'b0, condition_flag_out: 1'b0,
                           shift_result: 16'h0000, shift_amount_reg_one: 4'h0,
                           shift_amount_reg_two: 4'h0, mode: alu_pkg::FLAG_OVF};
        end else begin
            state_reg <= state_next;
        end
    end

    assign alu_result = state_reg.alu_result;
    assign carry_out = state_reg.carry_out;
    assign condition_flag_out = state_reg.condition_flag_out;
    assign shift_result = state_reg.shift_result;
    assign shift_amount_one = state_reg.shift_amount_reg_one;
    assign shift_amount_two = state_reg.shift_amount_reg_two;
endmodule // alu_flag_const_shift_ops
`default_nettype wire

// ==== core/alu_pkg.sv ====
// Types shared by the datapath slice.
`default_nettype none
package alu_pkg;
    typedef enum logic [3:0] {
        FLAG_OVF = 4'h1,
        FLAG_X2 = 4'h2,
        FLAG_X4 = 4'h4,
        FLAG_ZERO = 4'h8
    } flag_mode_type;
endpackage
`default_nettype wire

// ==== core/barrel_shifter.sv ====
// Combinational 16-bit barrel shifter: logical shifts and rotates by 0..15.
`include "alu_consts.svh"
`default_nettype none
module barrel_shifter (
    shift_if.shifter sif
);
    // Kind 0 logical right, 1 logical left, 2 rotate right, 3 rotate left.
    logic [31:0] doubled;
    always_comb begin
        doubled = {sif.data_in, sif.data_in};
        unique case (sif.kind)
            2'h0: sif.data_out = sif.data_in >> sif.amount;
            2'h1: sif.data_out = sif.data_in << sif.amount;
            2'h2: sif.data_out = 16'((doubled >> sif.amount));
            2'h3: sif.data_out = 16'((doubled << sif.amount) >> `DATA_W);
        endcase
    end
endmodule // barrel_shifter
`default_nettype wire

// ==== core/shift_if.sv ====
// Interface carrying shifter request and result between the slice and its shifter.
`default_nettype none
interface shift_if;
    logic [15:0] data_in;
    logic [3:0] amount;
    logic [1:0] kind;
    logic [15:0] data_out;
    modport requester (output data_in, output amount, output kind, input data_out);
    modport shifter (input data_in, input amount, input kind, output data_out);
endinterface
`default_nettype wire
